// *** design/lfr_map.svh ***
// register offsets, field positions, reset values and timing figures of the ldo fault register bank
// assumes an includer that uses the names only; definitions only, no logic
`ifndef LFR_MAP_SVH
`define LFR_MAP_SVH

`define LFR_ADDR_W 8
`define LFR_DATA_W 8
`define LFR_FLAG_W 6

`define LFR_OFS_FLAGS 8'h20
`define LFR_OFS_MASKS 8'h21
`define LFR_OFS_LIVE 8'h22
`define LFR_OFS_CHARGER 8'h23
`define LFR_OFS_POWER 8'h24
`define LFR_OFS_SCRATCH_FIRST 8'h25
`define LFR_OFS_SCRATCH_SECOND 8'h26

`define LFR_BIT_LINREG4 5
`define LFR_BIT_LINREG3 4
`define LFR_BIT_RAIL_3V3 3
`define LFR_BIT_CARD_RAIL 2
`define LFR_BIT_LINREG2 1
`define LFR_BIT_LINREG1 0

`define LFR_BIT_CHARGER_EN 3
`define LFR_VSEL_MSB 2
`define LFR_VSEL_LSB 0
`define LFR_BIT_SC_SHUTDOWN 7
`define LFR_BIT_LONG_PRESS_OFF 1
`define LFR_BIT_AUTO_RESTART 0

`define LFR_RST_FLAGS 6'h00
`define LFR_RST_MASKS 6'h3F
`define LFR_RST_CHARGER 4'h0
`define LFR_RST_SCRATCH 8'h00

`define LFR_CLOCK_HZ 50_000_000
`define LFR_LONG_PRESS_S 4
`define LFR_LONG_PRESS_CYCLES (`LFR_LONG_PRESS_S * `LFR_CLOCK_HZ)

`endif

// *** design/lfr_pkg.sv ***
// types shared by the ldo fault register bank files
// assumes lfr_map.svh for the numeric constants
package lfr_pkg;
  typedef enum logic [1:0] {
    lfr_press_idle,
    lfr_press_counting,
    lfr_press_fired
  } lfr_press_state_type;
endpackage

// *** design/lfr_scratch_mem.sv ***
// two battery-backed scratch bytes with registered read data
// assumes backup_por_n comes from the coin-cell supply domain and is the only reset these bytes see
`timescale 1ns/10ps
`include "lfr_map.svh"
module lfr_scratch_mem
  import lfr_pkg::*;
#(
  parameter int DEPTH = 2,
  parameter int WIDTH = `LFR_DATA_W
) (
  input wire logic clock,
  input wire logic backup_por_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_index,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic [WIDTH-1:0] rd_data
);
  localparam int IW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];

  // main reset is deliberately absent: contents survive main battery loss
  genvar e;
  generate
    for (e = 0; e < DEPTH; e++) begin : g_entry
      always_ff @(posedge clock or negedge backup_por_n) begin
        if (!backup_por_n) begin
          store[e] <= `LFR_RST_SCRATCH;
        end else if (wr_en && wr_index == IW'(e)) begin
          store[e] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge backup_por_n) begin
    if (!backup_por_n) begin
      rd_data <= `LFR_RST_SCRATCH;
    end else begin
      rd_data <= store[rd_index];
    end
  end
endmodule // lfr_scratch_mem

// *** design/lfr_long_press.sv ***
// power button hold timer: one pulse once the button has been held low for the full time
// assumes button_live is already synchronised to clock
`timescale 1ns/10ps
`include "lfr_map.svh"
module lfr_long_press
  import lfr_pkg::*;
#(
  parameter int HOLD_CYCLES = `LFR_LONG_PRESS_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic button_live,
  output logic held_pulse
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

  lfr_press_state_type state;
  logic [CW-1:0] count;

  // fires once per press; the button must be released before another pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= lfr_press_idle;
      count <= '0;
      held_pulse <= 1'b0;
    end else begin
      held_pulse <= 1'b0;
      case (state)
        lfr_press_idle: begin
          count <= '0;
          if (!button_live) begin
            state <= lfr_press_counting;
          end
        end
        lfr_press_counting: begin
          if (button_live) begin
            state <= lfr_press_idle;
          end else if (count == LAST) begin
            held_pulse <= 1'b1;
            state <= lfr_press_fired;
          end else begin
            count <= count + CW'(1);
          end
        end
        lfr_press_fired: begin
          if (button_live) begin
            state <= lfr_press_idle;
          end
        end
        default: begin
          state <= lfr_press_idle;
        end
      endcase
    end
  end
endmodule // lfr_long_press

// *** design/lfr_regs.sv ***
// ldo fault flags, masks, live state, charger and power control, scratch bytes
// assumes a serial control port on the same clock presents single-cycle read and write strobes
// What this block does
// - flag bits 5,4,3 for linreg4, linreg3, 3v3
// - flag bits 2,1,0 for card rail, linreg2, linreg1
// - flag stays set until written with one
// - writing zero leaves a flag unchanged
// - mask zero unmasks, mask one masks
// - unmasked flags drive interrupt pin; masked don't
// - mask bit shares position with its flag
// - live register read-only, tracks, never latches
// - live bit one above limit, zero normal
// - charger control bit 3 enables charger
// - charger bits 2:0 select output voltage
// - power bit 7 shuts overcurrent regulators down
// - power bit 1 allows off after hold
// - power bit 0 plus config restarts after off
// - scratch bytes survive main battery loss
// - only coin-cell reset clears scratch bytes
// - control registers accessible at any time
// - live bits after reset follow regulator state
// - button live bit follows button pin level
`timescale 1ns/10ps
`include "lfr_map.svh"
module lfr_regs
  import lfr_pkg::*;
#(
  parameter int LONG_PRESS_CYCLES = `LFR_LONG_PRESS_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic backup_por_n,
  input wire logic [`LFR_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [`LFR_DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [`LFR_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [`LFR_FLAG_W-1:0] overcurrent_in,
  input wire logic power_button_in,
  input wire logic power_config_bit,
  output logic irq_out_n,
  output logic [`LFR_FLAG_W-1:0] regulator_shutdown,
  output logic backup_charger_enable,
  output logic [`LFR_VSEL_MSB:0] backup_charge_voltage_sel,
  output logic enter_off_mode,
  output logic auto_restart_req,
  output logic power_button_live
);
  localparam int FW = `LFR_FLAG_W;

  logic [FW-1:0] oc_meta;
  logic [FW-1:0] ldo_fault_live_state;
  logic button_meta;
  logic button_sync;
  logic [FW-1:0] ldo_fault_flags;
  logic [FW-1:0] ldo_fault_masks;
  logic [7:0] power_behaviour_control;
  logic wr_flags;
  logic wr_masks;
  logic wr_charger;
  logic wr_power;
  logic wr_scratch;
  logic rd_pending;
  logic [`LFR_ADDR_W-1:0] rd_addr;
  logic [`LFR_DATA_W-1:0] scratch_rdata;
  logic [`LFR_DATA_W-1:0] next_rdata;
  logic held_pulse;

  assign wr_flags = reg_wr && reg_addr == `LFR_OFS_FLAGS;
  assign wr_masks = reg_wr && reg_addr == `LFR_OFS_MASKS;
  assign wr_charger = reg_wr && reg_addr == `LFR_OFS_CHARGER;
  assign wr_power = reg_wr && reg_addr == `LFR_OFS_POWER;
  assign wr_scratch = reg_wr && (reg_addr == `LFR_OFS_SCRATCH_FIRST || reg_addr == `LFR_OFS_SCRATCH_SECOND);

  // comparator outputs are asynchronous to clock; live bits appear two edges after the pin moves
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oc_meta <= '0;
      ldo_fault_live_state <= '0;
      button_meta <= 1'b1;
      button_sync <= 1'b1;
    end else begin
      oc_meta <= overcurrent_in;
      ldo_fault_live_state <= oc_meta;
      button_meta <= power_button_in;
      button_sync <= button_meta;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_button_live <= 1'b1;
    end else begin
      power_button_live <= button_sync;
    end
  end

  // clear first, then set, so a fault in the clearing cycle survives
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ldo_fault_flags <= `LFR_RST_FLAGS;
    end else begin
      ldo_fault_flags <= (ldo_fault_flags & ~(wr_flags ? reg_wdata[FW-1:0] : '0))
                         | ldo_fault_live_state;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ldo_fault_masks <= `LFR_RST_MASKS;
    end else if (wr_masks) begin
      ldo_fault_masks <= reg_wdata[FW-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~|(ldo_fault_flags & ~ldo_fault_masks);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {backup_charger_enable, backup_charge_voltage_sel} <= `LFR_RST_CHARGER;
    end else if (wr_charger) begin
      backup_charger_enable <= reg_wdata[`LFR_BIT_CHARGER_EN];
      backup_charge_voltage_sel <= reg_wdata[`LFR_VSEL_MSB:`LFR_VSEL_LSB];
    end
  end

  // only bits 7, 1 and 0 are implemented; the rest read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_behaviour_control <= 8'h00;
    end else if (wr_power) begin
      power_behaviour_control <= reg_wdata & 8'h83;
    end
  end

  // a shut regulator stays off until its flag is cleared or protection is disabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regulator_shutdown <= '0;
    end else if (!power_behaviour_control[`LFR_BIT_SC_SHUTDOWN]) begin
      regulator_shutdown <= '0;
    end else begin
      regulator_shutdown <= (regulator_shutdown & ~(wr_flags ? reg_wdata[FW-1:0] : '0))
                            | ldo_fault_live_state;
    end
  end

  lfr_long_press #(
    .HOLD_CYCLES(LONG_PRESS_CYCLES)
  ) u_long_press (
    .clock(clock),
    .rst(rst),
    .button_live(button_sync),
    .held_pulse(held_pulse)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enter_off_mode <= 1'b0;
      auto_restart_req <= 1'b0;
    end else begin
      enter_off_mode <= held_pulse && power_behaviour_control[`LFR_BIT_LONG_PRESS_OFF];
      auto_restart_req <= held_pulse && power_behaviour_control[`LFR_BIT_LONG_PRESS_OFF]
                          && power_behaviour_control[`LFR_BIT_AUTO_RESTART] && power_config_bit;
    end
  end

  lfr_scratch_mem #(
    .DEPTH(2),
    .WIDTH(`LFR_DATA_W)
  ) u_scratch (
    .clock(clock),
    .backup_por_n(backup_por_n),
    .wr_en(wr_scratch),
    .wr_index(reg_addr == `LFR_OFS_SCRATCH_SECOND),
    .wr_data(reg_wdata),
    .rd_index(reg_addr == `LFR_OFS_SCRATCH_SECOND),
    .rd_data(scratch_rdata)
  );

  // two-cycle read so scratch and local registers share one latency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_pending <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_pending <= reg_rd;
      rd_addr <= reg_addr;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (rd_addr)
      `LFR_OFS_FLAGS: next_rdata = {2'b00, ldo_fault_flags};
      `LFR_OFS_MASKS: next_rdata = {2'b00, ldo_fault_masks};
      `LFR_OFS_LIVE: next_rdata = {2'b00, ldo_fault_live_state};
      `LFR_OFS_CHARGER: next_rdata = {4'h0, backup_charger_enable, backup_charge_voltage_sel};
      `LFR_OFS_POWER: next_rdata = power_behaviour_control;
      `LFR_OFS_SCRATCH_FIRST: next_rdata = scratch_rdata;
      `LFR_OFS_SCRATCH_SECOND: next_rdata = scratch_rdata;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pending;
      reg_rdata <= rd_pending ? next_rdata : 8'h00;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_fault_sets_flag;
    |ldo_fault_live_state |=> ((ldo_fault_flags & $past(ldo_fault_live_state)) == $past(ldo_fault_live_state));
  endproperty
  a_fault_sets_flag: assert property (p_fault_sets_flag) else $error("live fault did not set its flag");

  property p_set_beats_clear;
    wr_flags && |(reg_wdata[FW-1:0] & ldo_fault_live_state) |=> |ldo_fault_flags;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear won over live fault");

  property p_one_clears;
    wr_flags ##0 (ldo_fault_live_state == '0)
      |=> ((ldo_fault_flags & $past(reg_wdata[FW-1:0])) == '0);
  endproperty
  a_one_clears: assert property (p_one_clears) else $error("written one failed to clear flag");

  property p_zero_keeps;
    wr_flags |=> ((ldo_fault_flags & $past(ldo_fault_flags & ~reg_wdata[FW-1:0]))
                  == $past(ldo_fault_flags & ~reg_wdata[FW-1:0]));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("written zero changed a flag");

  property p_irq_follows;
    ##1 (irq_out_n == !$past(|(ldo_fault_flags & ~ldo_fault_masks)));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt pin disagrees with flags and masks");

  property p_live_read;
    reg_rd && reg_addr == `LFR_OFS_LIVE |-> ##2 (reg_rvalid && reg_rdata == {2'b00, $past(ldo_fault_live_state)});
  endproperty
  a_live_read: assert property (p_live_read) else $error("live register read wrong value");

  property p_no_shutdown_when_off;
    !power_behaviour_control[`LFR_BIT_SC_SHUTDOWN] |=> regulator_shutdown == '0;
  endproperty
  a_no_shutdown_when_off: assert property (p_no_shutdown_when_off) else $error("shutdown while disabled");

  property p_off_needs_enable;
    enter_off_mode |-> $past(power_behaviour_control[`LFR_BIT_LONG_PRESS_OFF]) && !$past(button_sync, 2);
  endproperty
  a_off_needs_enable: assert property (p_off_needs_enable) else $error("off mode without enable or press");

  property p_restart_gated;
    auto_restart_req |-> enter_off_mode && $past(power_config_bit);
  endproperty
  a_restart_gated: assert property (p_restart_gated) else $error("restart without off or config bit");

  property p_charger_write;
    wr_charger |=> backup_charger_enable == $past(reg_wdata[`LFR_BIT_CHARGER_EN])
                   && backup_charge_voltage_sel == $past(reg_wdata[`LFR_VSEL_MSB:`LFR_VSEL_LSB]);
  endproperty
  a_charger_write: assert property (p_charger_write) else $error("charger control write lost");

  property p_mask_write;
    wr_masks |=> ldo_fault_masks == $past(reg_wdata[FW-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_flag_holds;
    !wr_flags && ldo_fault_live_state == '0 |=> ldo_fault_flags == $past(ldo_fault_flags);
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag changed without fault or clear");

  property p_shutdown_on_fault;
    power_behaviour_control[`LFR_BIT_SC_SHUTDOWN] && |ldo_fault_live_state
      |=> ((regulator_shutdown & $past(ldo_fault_live_state)) == $past(ldo_fault_live_state));
  endproperty
  a_shutdown_on_fault: assert property (p_shutdown_on_fault) else $error("fault did not shut regulator");

  property p_power_write;
    wr_power |=> power_behaviour_control == ($past(reg_wdata) & 8'h83);
  endproperty
  a_power_write: assert property (p_power_write) else $error("power control write lost");

  c_irq_asserted: cover property (irq_out_n ##1 !irq_out_n);
  c_clear_race: cover property (wr_flags && |(reg_wdata[FW-1:0] & ldo_fault_live_state));
  c_off_restart: cover property (auto_restart_req);
  c_shutdown: cover property (|regulator_shutdown);
  c_off_no_restart: cover property (enter_off_mode && !auto_restart_req);
endmodule // lfr_regs

// *** verification/lfr_host.sv ***
// host model: drives the register strobe port of the fault register bank
// assumes every task is entered just after a rising clock edge
`timescale 1ns/10ps
module lfr_host (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one strobe cycle then one idle edge, so back-to-back calls never retoggle a strobe in one step;
  // the idle bus shows inverted values so stale data cannot pass
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge clock);
    #1;
  endtask
endmodule // lfr_host

// *** verification/testbench.sv ***
// self-checking bench for the ldo fault register bank
// assumes lfr_map.svh offsets and a 20-cycle long-press hold
`timescale 1ns/10ps
`include "lfr_map.svh"
module testbench;
  logic clock, rst, backup_por_n, power_button_in, power_config_bit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, s1, s2;
  logic reg_wr, reg_rd, reg_rvalid, irq_out_n, backup_charger_enable;
  logic enter_off_mode, auto_restart_req, power_button_live;
  logic [5:0] overcurrent_in, regulator_shutdown;
  logic [2:0] backup_charge_voltage_sel;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 32'h951b;

  lfr_host u_lfr_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  lfr_regs #(.LONG_PRESS_CYCLES(20)) u_lfr_regs (.clock(clock), .rst(rst), .backup_por_n(backup_por_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .overcurrent_in(overcurrent_in), .power_button_in(power_button_in),
    .power_config_bit(power_config_bit), .irq_out_n(irq_out_n), .regulator_shutdown(regulator_shutdown),
    .backup_charger_enable(backup_charger_enable), .backup_charge_voltage_sel(backup_charge_voltage_sel),
    .enter_off_mode(enter_off_mode), .auto_restart_req(auto_restart_req), .power_button_live(power_button_live));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic complete_run;
    $display("counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    tests_run++;
    if (a !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_lfr_host.access(1'b1, a, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_lfr_host.access(1'b0, a, 8'h00);
  endtask

  // hold the button for 40 cycles, count off pulses, then release
  task automatic press(input logic eo, input logic er);
    int seen = 0;
    power_button_in = 1'b0;
    repeat (40) begin
      @(negedge clock);
      if (enter_off_mode === 1'b1) begin
        seen++;
        chk(auto_restart_req, er);
      end
    end
    chk(power_button_live, 8'h00);
    chk(8'(seen), 8'(eo));
    @(posedge clock);
    #1;
    power_button_in = 1'b1;
    cyc(4);
  endtask

  // read answers are matched to the oldest pending note
  always @(negedge clock) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("unexpected at %0t: read answer with nothing pending", $time);
      end else begin
        chk(reg_rdata, exp_q.pop_front());
      end
    end
  end

  initial begin
    #(20 * 5000);
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    rst = 1'b1;
    backup_por_n = 1'b0;
    overcurrent_in = 6'h00;
    power_button_in = 1'b1;
    power_config_bit = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    backup_por_n = 1'b1;
    rd(`LFR_OFS_MASKS, 8'h3f);
    rd(`LFR_OFS_LIVE, 8'h00);
    rd(`LFR_OFS_FLAGS, 8'h00);
    rd(`LFR_OFS_POWER, 8'h00);
    rd(8'h27, 8'h00);
    chk(irq_out_n, 8'h01);
    chk(power_button_live, 8'h01);
    $display("test reset done");
    wr(`LFR_OFS_MASKS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      overcurrent_in = 6'(1 << i);
      cyc(5);
      rd(`LFR_OFS_LIVE, 8'(1 << i));
      rd(`LFR_OFS_FLAGS, 8'(1 << i));
      chk(irq_out_n, 8'h00);
      chk(regulator_shutdown, 8'h00);
      wr(`LFR_OFS_FLAGS, 8'(1 << i));
      rd(`LFR_OFS_FLAGS, 8'(1 << i));
      overcurrent_in = 6'h00;
      cyc(3);
      rd(`LFR_OFS_LIVE, 8'h00);
      wr(`LFR_OFS_FLAGS, 8'hff ^ 8'(1 << i));
      rd(`LFR_OFS_FLAGS, 8'(1 << i));
      wr(`LFR_OFS_FLAGS, 8'(1 << i));
      cyc(2);
      rd(`LFR_OFS_FLAGS, 8'h00);
      chk(irq_out_n, 8'h01);
    end
    $display("test flags done");
    wr(`LFR_OFS_MASKS, 8'h08);
    overcurrent_in = 6'h08;
    cyc(5);
    chk(irq_out_n, 8'h01);
    wr(`LFR_OFS_MASKS, 8'h37);
    cyc(2);
    chk(irq_out_n, 8'h00);
    wr(`LFR_OFS_LIVE, 8'h00);
    rd(`LFR_OFS_LIVE, 8'h08);
    overcurrent_in = 6'h00;
    cyc(3);
    wr(`LFR_OFS_FLAGS, 8'h08);
    wr(`LFR_OFS_MASKS, 8'h00);
    cyc(2);
    chk(irq_out_n, 8'h01);
    $display("test masks done");
    wr(`LFR_OFS_POWER, 8'h80);
    overcurrent_in = 6'h01;
    cyc(5);
    chk(regulator_shutdown, 8'h01);
    overcurrent_in = 6'h00;
    wr(`LFR_OFS_FLAGS, 8'h01);
    cyc(3);
    wr(`LFR_OFS_FLAGS, 8'h01);
    cyc(2);
    chk(regulator_shutdown, 8'h00);
    wr(`LFR_OFS_POWER, 8'h00);
    $display("test shutdown done");
    repeat (4) begin
      d = 8'($random(seed));
      wr(`LFR_OFS_CHARGER, d);
      rd(`LFR_OFS_CHARGER, d & 8'h0f);
      chk(backup_charger_enable, d[3]);
      chk(backup_charge_voltage_sel, d[2:0]);
    end
    $display("test charger done");
    s1 = 8'($random(seed));
    s2 = 8'($random(seed));
    wr(`LFR_OFS_SCRATCH_FIRST, s1);
    wr(`LFR_OFS_SCRATCH_SECOND, s2);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd(`LFR_OFS_SCRATCH_FIRST, s1);
    rd(`LFR_OFS_SCRATCH_SECOND, s2);
    rd(`LFR_OFS_CHARGER, 8'h00);
    backup_por_n = 1'b0;
    cyc(2);
    backup_por_n = 1'b1;
    rd(`LFR_OFS_SCRATCH_FIRST, 8'h00);
    rd(`LFR_OFS_SCRATCH_SECOND, 8'h00);
    $display("test scratch done");
    wr(`LFR_OFS_POWER, 8'h03);
    power_config_bit = 1'b1;
    press(1'b1, 1'b1);
    chk(power_button_live, 8'h01);
    power_config_bit = 1'b0;
    press(1'b1, 1'b0);
    wr(`LFR_OFS_POWER, 8'h00);
    press(1'b0, 1'b0);
    $display("test long press done");
    cyc(4);
    chk(8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule // testbench
